// ==== verilog/pin_select_pkg.sv ====
package pin_select_pkg;

  localparam int CODE_W          = 5;
  localparam int REG_W           = 16;
  localparam int DATA_W          = 32;
  localparam int ADDR_W          = 8;
  localparam int NUM_OUT_REGS    = 6;
  localparam int NUM_OUT_PINS    = 2 * NUM_OUT_REGS;
  localparam int NUM_IN_PINS     = 26;
  localparam int NUM_FUNCS       = 32;

  // byte addresses on the register bus, one aligned word each
  localparam logic [ADDR_W-1:0] ADDR_FRAME_SYNC_SEL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CAN_RX_SEL     = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_OUT_SEL_BASE   = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_OUT_SEL_LAST   = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_ROUTE_STATUS   = 8'h20;

  // field positions
  localparam int LO_FIELD_LSB    = 0;
  localparam int HI_FIELD_LSB    = 8;
  localparam int STAT_OE_LSB     = 0;
  localparam int STAT_FS_BIT     = 16;
  localparam int STAT_CAN_BIT    = 17;

  typedef logic [CODE_W-1:0] code_t;

  // reset values and special codes
  localparam code_t IN_CODE_RST  = 5'h1f;
  localparam code_t OUT_CODE_RST = 5'h00;
  localparam code_t GROUND_CODE  = 5'h1f;
  localparam code_t NO_FUNC_CODE = 5'h00;

endpackage

// ==== verilog/route_if.sv ====
`timescale 1ns/10ps
interface route_if
  import pin_select_pkg::*;
#(
  parameter int NUM_OUT = NUM_OUT_PINS
);
  code_t                   fs_code;
  code_t                   can_code;
  logic                    can_en;
  code_t [NUM_OUT-1:0]     out_code;

  modport ctrl
  (
    output fs_code,
    output can_code,
    output can_en,
    output out_code
  );

  modport route
  (
    input  fs_code,
    input  can_code,
    input  can_en,
    input  out_code
  );
endinterface

// ==== verilog/input_route.sv ====
`timescale 1ns/10ps
module input_route
  import pin_select_pkg::*;
#(
  parameter int NUM_IN = NUM_IN_PINS
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  route_if.route                 rif,
  input  wire logic [NUM_IN-1:0] pin_in,
  output logic                   frame_sync_out,
  output logic                   can_out
);

  typedef struct packed
  {
    logic fs;
    logic can;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // ground code and codes past the last pin both read as low
  function automatic logic pick(input code_t code, input logic [NUM_IN-1:0] pins);
    logic v;
    v = 1'b0;
    if (code != GROUND_CODE && int'(code) < NUM_IN)
    begin
      v = pins[code];
    end
    return v;
  endfunction

  always_comb
  begin
    s_nxt     = s_r;
    s_nxt.fs  = pick(rif.fs_code, pin_in);
    s_nxt.can = rif.can_en & pick(rif.can_code, pin_in);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign frame_sync_out = s_r.fs;
  assign can_out        = s_r.can;

endmodule

// ==== verilog/output_route.sv ====
`timescale 1ns/10ps
module output_route
  import pin_select_pkg::*;
#(
  parameter int NUM_OUT = NUM_OUT_PINS,
  parameter int NUM_FN  = NUM_FUNCS
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  route_if.route                 rif,
  input  wire logic [NUM_FN-1:0] func_in,
  output logic [NUM_OUT-1:0]     pin_out,
  output logic [NUM_OUT-1:0]     pin_oe
);

  typedef struct packed
  {
    logic [NUM_OUT-1:0] dout;
    logic [NUM_OUT-1:0] oe;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // code zero leaves the pin undriven so the port logic keeps it
  always_comb
  begin
    s_nxt = s_r;
    for (int i = 0; i < NUM_OUT; i++)
    begin
      s_nxt.oe[i]   = (rif.out_code[i] != NO_FUNC_CODE);
      s_nxt.dout[i] = (int'(rif.out_code[i]) < NUM_FN) ? func_in[rif.out_code[i]] : 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign pin_out = s_r.dout;
  assign pin_oe  = s_r.oe;

endmodule

// ==== verilog/pin_select_map.sv ====
`timescale 1ns/10ps
// Overview of operation
// - input select code all ones ties the peripheral input to ground
// - input select code n routes remappable pin n to the input
// - frame sync input follows the pin chosen by bits 4-0 of its register
// - can receive input follows the pin chosen by bits 4-0 of its register
// - without the can controller its input select register is disabled
// - input select bits 15-5 read zero; fields reset to all ones
// - output select k: bits 4-0 drive pin 2k, bits 12-8 pin 2k+1
// - output select bits 15-13 and 7-5 read zero; fields reset to zero
// - six output select registers cover pins 0 to 11
module pin_select_map
  import pin_select_pkg::*;
#(
  parameter bit CAN_PRESENT = 1'b1,
  parameter int NUM_IN      = NUM_IN_PINS,
  parameter int NUM_FN      = NUM_FUNCS
)
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [DATA_W-1:0]   pwdata,
  output logic [DATA_W-1:0]        prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NUM_IN-1:0]   remappable_pin_in,
  input  wire logic [NUM_FN-1:0]   periph_func_out,
  output logic [NUM_OUT_PINS-1:0]  remappable_pin_out,
  output logic [NUM_OUT_PINS-1:0]  remappable_pin_oe,
  output logic                     codec_frame_sync_in,
  output logic                     can_receive_in
);

  typedef enum logic
  {
    ST_IDLE,
    ST_ACCESS
  } bus_state_t;

  typedef struct packed
  {
    bus_state_t                   state;
    code_t                        frame_sync_pin_code;
    code_t                        can_rx_pin_code;
    code_t [NUM_OUT_PINS-1:0]     pin_function_code;
    logic [DATA_W-1:0]            rdata;
    logic                         ready;
    logic                         err;
  } state_t;

  localparam state_t STATE_RST = '{
    state:               ST_IDLE,
    frame_sync_pin_code: IN_CODE_RST,
    can_rx_pin_code:     IN_CODE_RST,
    pin_function_code:   {NUM_OUT_PINS{OUT_CODE_RST}},
    rdata:               '0,
    ready:               1'b0,
    err:                 1'b0
  };

  state_t s_r;
  state_t s_nxt;

  logic   fs_level;
  logic   can_level;

  route_if #(.NUM_OUT(NUM_OUT_PINS)) rif ();

  // address of an output select register, aligned and in range
  function automatic logic is_out_sel(input logic [ADDR_W-1:0] a);
    return (a >= ADDR_OUT_SEL_BASE) && (a <= ADDR_OUT_SEL_LAST) && (a[1:0] == 2'b00);
  endfunction

  // which output select register, 0 to 5
  function automatic int out_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - ADDR_OUT_SEL_BASE;
    return int'(off[ADDR_W-1:2]);
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    return (a == ADDR_FRAME_SYNC_SEL) || (a == ADDR_CAN_RX_SEL)
        || is_out_sel(a) || (a == ADDR_ROUTE_STATUS);
  endfunction

  // read value; unimplemented bits come back zero
  function automatic logic [DATA_W-1:0] read_word
  (
    input state_t              st,
    input logic [ADDR_W-1:0]   a,
    input logic [NUM_OUT_PINS-1:0] oe,
    input logic                fs,
    input logic                can
  );
    logic [DATA_W-1:0] w;
    int                k;
    w = '0;
    k = 0;
    if (a == ADDR_FRAME_SYNC_SEL)
    begin
      w[LO_FIELD_LSB +: CODE_W] = st.frame_sync_pin_code;
    end
    else if (a == ADDR_CAN_RX_SEL)
    begin
      if (CAN_PRESENT)
      begin
        w[LO_FIELD_LSB +: CODE_W] = st.can_rx_pin_code;
      end
    end
    else if (is_out_sel(a))
    begin
      k = out_index(a);
      w[LO_FIELD_LSB +: CODE_W] = st.pin_function_code[2*k];
      w[HI_FIELD_LSB +: CODE_W] = st.pin_function_code[2*k+1];
    end
    else if (a == ADDR_ROUTE_STATUS)
    begin
      w[STAT_OE_LSB +: NUM_OUT_PINS] = oe;
      w[STAT_FS_BIT]                 = fs;
      w[STAT_CAN_BIT]                = can;
    end
    return w;
  endfunction

  always_comb
  begin
    int k;
    k = 0;
    s_nxt = s_r;
    case (s_r.state)
      ST_IDLE:
      begin
        s_nxt.ready = 1'b0;
        s_nxt.err   = 1'b0;
        if (psel && !penable)
        begin
          // read data is sampled in the setup cycle, so the slave
          // answers with no wait state
          s_nxt.rdata = read_word(s_r, paddr, remappable_pin_oe, fs_level, can_level);
          s_nxt.err   = !addr_hit(paddr);
          s_nxt.ready = 1'b1;
          s_nxt.state = ST_ACCESS;
        end
      end
      ST_ACCESS:
      begin
        if (psel && penable && pwrite && !s_r.err)
        begin
          if (paddr == ADDR_FRAME_SYNC_SEL)
          begin
            s_nxt.frame_sync_pin_code = pwdata[LO_FIELD_LSB +: CODE_W];
          end
          else if (paddr == ADDR_CAN_RX_SEL)
          begin
            // disabled register takes no write but is no bus error
            if (CAN_PRESENT)
            begin
              s_nxt.can_rx_pin_code = pwdata[LO_FIELD_LSB +: CODE_W];
            end
          end
          else if (is_out_sel(paddr))
          begin
            k = out_index(paddr);
            s_nxt.pin_function_code[2*k]   = pwdata[LO_FIELD_LSB +: CODE_W];
            s_nxt.pin_function_code[2*k+1] = pwdata[HI_FIELD_LSB +: CODE_W];
          end
        end
        s_nxt.ready = 1'b0;
        s_nxt.err   = 1'b0;
        s_nxt.rdata = '0;
        s_nxt.state = ST_IDLE;
      end
      default:
      begin
        s_nxt = STATE_RST;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= STATE_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign rif.fs_code  = s_r.frame_sync_pin_code;
  assign rif.can_code = s_r.can_rx_pin_code;
  assign rif.can_en   = CAN_PRESENT;
  assign rif.out_code = s_r.pin_function_code;

  input_route #(
    .NUM_IN (NUM_IN)
  ) u_input_route (
    .pclk           (pclk),
    .presetn        (presetn),
    .rif            (rif),
    .pin_in         (remappable_pin_in),
    .frame_sync_out (fs_level),
    .can_out        (can_level)
  );

  output_route #(
    .NUM_OUT (NUM_OUT_PINS),
    .NUM_FN  (NUM_FN)
  ) u_output_route (
    .pclk    (pclk),
    .presetn (presetn),
    .rif     (rif),
    .func_in (periph_func_out),
    .pin_out (remappable_pin_out),
    .pin_oe  (remappable_pin_oe)
  );

  assign codec_frame_sync_in = fs_level;
  assign can_receive_in      = can_level;
  assign prdata              = s_r.rdata;
  assign pready              = s_r.ready;
  assign pslverr             = s_r.err;

endmodule

// ==== verif/pin_env.sv ====
`timescale 1ns/10ps
module pin_env
(
  input  wire logic        pclk,
  output logic [25:0]      pin_in,
  output logic [31:0]      func
);
  logic [31:0] cnt_r = 32'h0;
  // odd step: every pin toggles at its own rate; functions i and i+16 are equal
  always @(posedge pclk)
    cnt_r <= cnt_r + 32'h6b5a3c97;
  assign pin_in = cnt_r[31:6] ^ cnt_r[25:0];
  assign func   = cnt_r ^ {cnt_r[15:0], cnt_r[31:16]};
endmodule

// ==== verif/pin_select_map_monitor.sv ====
`timescale 1ns/10ps
module pin_select_mon
  import pin_select_pkg::*;
#(
  parameter bit CAN_PRESENT = 1'h1,
  parameter int NUM_IN      = NUM_IN_PINS
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [NUM_IN-1:0] remappable_pin_in,
  input wire logic              codec_frame_sync_in,
  input wire logic              can_receive_in
);
  code_t fs_r;
  code_t can_r;
  logic  wr_en;
  logic  fs_x;
  logic  can_x;
  assign wr_en = psel & penable & pready & pwrite;
  assign fs_x  = (fs_r < NUM_IN) ? remappable_pin_in[fs_r] : 1'h0;
  assign can_x = (can_r < NUM_IN && CAN_PRESENT) ? remappable_pin_in[can_r] : 1'h0;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      fs_r  <= IN_CODE_RST;
      can_r <= IN_CODE_RST;
    end
    else if (wr_en && paddr == ADDR_FRAME_SYNC_SEL)
      fs_r <= pwdata[4:0];
    else if (wr_en && paddr == ADDR_CAN_RX_SEL)
      can_r <= pwdata[4:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  fs_route_a:
    assert property (codec_frame_sync_in == $past(fs_x)) else $error("frame sync route wrong");
  can_route_a:
    assert property (can_receive_in == $past(can_x)) else $error("can route wrong");
  ready_next_a:
    assert property (psel && !penable |=> pready) else $error("no ready after setup");
  ready_pulse_a:
    assert property (pready |=> !pready) else $error("ready held too long");
  unmapped_err_a:
    assert property (pready && paddr > ADDR_ROUTE_STATUS |-> pslverr && prdata == 32'h0)
      else $error("unmapped not refused");
  mapped_ok_a:
    assert property (pready && paddr <= ADDR_ROUTE_STATUS && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped refused");
  in_read_a:
    assert property (pready && !pwrite && paddr == ADDR_FRAME_SYNC_SEL |-> prdata == {27'h0, fs_r})
      else $error("input select readback wrong");
  out_resv_a:
    assert property (pready && !pwrite && paddr inside {[ADDR_OUT_SEL_BASE:ADDR_OUT_SEL_LAST]}
      |-> (prdata & 32'hffffe0e0) == 32'h0) else $error("reserved bits set");
  idle_quiet_a:
    assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("bus not quiet");
  cover property (wr_en && paddr == ADDR_CAN_RX_SEL);
  cover property (pready && pslverr);
  cover property (fs_r == 5'h19 && codec_frame_sync_in);
endmodule

bind pin_select_map pin_select_mon #(.CAN_PRESENT(CAN_PRESENT), .NUM_IN(NUM_IN)) mon
(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
 .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .remappable_pin_in(remappable_pin_in),
 .codec_frame_sync_in(codec_frame_sync_in), .can_receive_in(can_receive_in));

// ==== verif/pin_select_map_tb.sv ====
`timescale 1ns/10ps
module pin_select_map_tb
  import pin_select_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [25:0] pin_in;
  logic [31:0] func;
  logic [11:0] pin_out;
  logic [11:0] pin_oe;
  logic        fs;
  logic        can;
  logic [31:0] q;
  logic [31:0] q2;
  logic [31:0] prdata2;
  logic        can2;
  logic        e;
  logic [11:0] ev;
  int          n_fail;
  int          n_checks;
  int          k;
  int          j;
  pin_select_map dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remappable_pin_in(pin_in), .periph_func_out(func), .remappable_pin_out(pin_out),
    .remappable_pin_oe(pin_oe), .codec_frame_sync_in(fs), .can_receive_in(can));
  pin_env env (.pclk(pclk), .pin_in(pin_in), .func(func));
  // second copy without the can controller shares the bus and the pins
  pin_select_map #(.CAN_PRESENT(1'b0)) dut_nocan (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata2),
    .pready(), .pslverr(), .remappable_pin_in(pin_in), .periph_func_out(func),
    .remappable_pin_out(), .remappable_pin_oe(), .codec_frame_sync_in(), .can_receive_in(can2));
  function automatic code_t oc(input int p);
    return (p == 11) ? 5'h1f : code_t'(p + 1);
  endfunction
  function automatic logic [31:0] rb(input int r);
    return {19'h0, oc(2 * r + 1), 3'h0, oc(2 * r)};
  endfunction
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      $display("wrong value %s exp %h got %h", s, x, g);
      n_fail++;
    end
  endtask
  // request held until the edge that sees pready; no release, so back-to-back is possible
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic xe);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // wait ends on the edge that sees pready high; the watchdog catches a slave that never answers
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'h1);
    q  = prdata;
    q2 = prdata2;
    e = pslverr;
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    xfer(1'h0, a, 32'h0, xe);
    chk("prdata", x, q);
  endtask
  task automatic idle;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic reset_vals;
    rd(ADDR_FRAME_SYNC_SEL, 32'h1f, 1'h0);
    rd(ADDR_CAN_RX_SEL, 32'h1f, 1'h0);
    chk("can sel off", 32'h0, q2);
    for (k = 0; k < 6; k++)
      rd(ADDR_OUT_SEL_BASE + 8'(4 * k), 32'h0, 1'h0);
    chk("oe", 32'h0, {20'h0, pin_oe});
  endtask
  task automatic route(input code_t a, input code_t b);
    logic [1:0] v;
    xfer(1'h1, ADDR_FRAME_SYNC_SEL, {27'h7ffffff, a}, 1'h0);
    xfer(1'h1, ADDR_CAN_RX_SEL, {27'h0, b}, 1'h0);
    idle();
    repeat (4)
    begin
      v = {b < 26 ? pin_in[b] : 1'h0, a < 26 ? pin_in[a] : 1'h0};
      @(posedge pclk);
      chk("route", {30'h0, v}, {30'h0, can, fs});
      chk("can off", 32'h0, {31'h0, can2});
    end
  endtask
  task automatic stop_test;
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    #500000;
    n_fail++;
    stop_test();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    reset_vals();
    route(5'h00, 5'h19);
    rd(ADDR_FRAME_SYNC_SEL, 32'h0, 1'h0);
    route(5'h01, 5'h1f);
    route(5'h19, 5'h00);
    route(5'h1f, 5'h01);
    for (k = 0; k < 6; k++)
      xfer(1'h1, ADDR_OUT_SEL_BASE + 8'(4 * k), 32'hffffe0e0 | rb(k), 1'h0);
    for (k = 0; k < 6; k++)
      rd(ADDR_OUT_SEL_BASE + 8'(4 * k), rb(k), 1'h0);
    idle();
    for (j = 0; j < 3; j++)
    begin
      for (k = 0; k < 12; k++)
        ev[k] = func[oc(k)];
      @(posedge pclk);
      chk("pin_out", {20'h0, ev}, {20'h0, pin_out});
      chk("oe", 32'hfff, {20'h0, pin_oe});
    end
    xfer(1'h1, ADDR_OUT_SEL_BASE, 32'h0, 1'h0);
    xfer(1'h1, ADDR_CAN_RX_SEL, 32'h1f, 1'h0);
    rd(8'h24, 32'h0, 1'h1);
    xfer(1'h1, 8'h40, 32'h1f, 1'h1);
    idle();
    @(posedge pclk);
    chk("oe", 32'hffc, {20'h0, pin_oe});
    // status: enables plus both grounded inputs low
    rd(ADDR_ROUTE_STATUS, 32'hffc, 1'h0);
    idle();
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    reset_vals();
    stop_test();
  end
endmodule
